// >>> scs_shutdown_cause_recorder.sv
//------------------------------------------------------------------------------
// Purpose: Records which conditions caused each global shutdown.
// Assumes: RESET is the backup supply undervoltage reset, synchronous to CLK.
// Notes:   Register reads arrive from the serial interface on the same clock.
//------------------------------------------------------------------------------
// Operation
// - Reset input shutdown sets bit 7.
// - Battery undervoltage shutdown sets bit 6.
// - Recovery enabled allows restart after brief dropout.
// - Battery overvoltage shutdown sets bit 5.
// - Enabled battery-low shutdown sets bit 4.
// - Thermal overload shutdown sets bit 3.
// - Manual hard reset shutdown sets bit 2.
// - Watchdog expiry shutdown sets bit 1.
// - Shutdown pin shutdown sets bit 0.
`include "scs_params.svh"

module scs_shutdown_cause_recorder #(
    parameter int RECOVER_CYC = `SCS_RECOVER_CYC
) (
    input wire logic CLK,
    input wire logic RESET,
    input wire logic CE,
    input wire logic GLOBAL_SHUTDOWN,
    input wire logic EXTERNAL_RESET_INPUT,
    input wire logic BATT_UNDERVOLTAGE,
    input wire logic BATT_OVERVOLTAGE,
    input wire logic BATT_LOW,
    input wire logic LOW_BATTERY_SHUTDOWN_ENABLE,
    input wire logic THERMAL_OVERLOAD,
    input wire logic HARD_RESET_EVENT,
    input wire logic WATCHDOG_EXPIRED,
    input wire logic SHUTDOWN_PIN,
    input wire logic MOMENTARY_POWER_LOSS_RECOVERY,
    input wire logic RD_STB,
    input wire logic [7:0] RD_ADDR,
    output logic [7:0] RD_DATA,
    output logic RD_VALID,
    output logic RESTART_REQ
);

    // -------------------------------------------------------------------------
    // Cause input synchronisation
    // -------------------------------------------------------------------------
    // Raw pins and monitor outputs, gathered in register bit order.
    logic [7:0] cause_raw;
    // Synchronised copies of the same.
    logic [7:0] cause_sync;
    // Live synchronised cause vector, sampled by the log at a shutdown.
    scs_pkg::scs_cause_type cause_s;

    // The low-battery enable is left out of the raw vector (bit 4 is BATT_LOW);
    // it is applied after synchronisation because it comes from this clock.
    assign cause_raw = {EXTERNAL_RESET_INPUT, BATT_UNDERVOLTAGE, BATT_OVERVOLTAGE, BATT_LOW,
                        THERMAL_OVERLOAD, HARD_RESET_EVENT, WATCHDOG_EXPIRED, SHUTDOWN_PIN};

    // All cause sources come from other supplies or pins, so each gets two flops.
    scs_sync #(
        .WIDTH(8)
    ) u_sync (
        .clk(CLK),
        .reset(RESET),
        .ce(CE),
        .d(cause_raw),
        .q(cause_sync)
    );

    // Map the synchronised levels onto the cause fields.
    always_comb begin
        cause_s.reset_input_cause = cause_sync[`SCS_BIT_RESET_INPUT];
        cause_s.battery_undervoltage_cause = cause_sync[`SCS_BIT_BATT_UV];
        cause_s.battery_overvoltage_cause = cause_sync[`SCS_BIT_BATT_OV];
        cause_s.battery_low_cause = cause_sync[`SCS_BIT_BATT_LOW] & LOW_BATTERY_SHUTDOWN_ENABLE;
        cause_s.thermal_overload_cause = cause_sync[`SCS_BIT_THERMAL];
        cause_s.manual_hard_reset_cause = cause_sync[`SCS_BIT_HARD_RESET];
        cause_s.watchdog_cause = cause_sync[`SCS_BIT_WATCHDOG];
        cause_s.shutdown_pin_cause = cause_sync[`SCS_BIT_SHUTDOWN_PIN];
    end

    // -------------------------------------------------------------------------
    // Cause log and read port
    // -------------------------------------------------------------------------
    logic [7:0] log_r;      // The shutdown cause log itself.
    logic [7:0] log_nxt;
    logic [7:0] rd_data_r;  // Registered read data.
    logic [7:0] rd_data_nxt;
    logic rd_valid_r;       // One-cycle answer strobe.
    logic rd_valid_nxt;
    logic log_read;         // A read of the log address this cycle.
    logic [7:0] set_vec;    // Bits to set on a shutdown.

    // A read at the log address is the only way software affects the log;
    // there is no write path, so the register is read-only by construction.
    assign log_read = RD_STB && (RD_ADDR == `SCS_LOG_ADDR);

    // Next-state logic for the log and read data.
    always_comb begin
        set_vec = 8'h00;
        // Only a real shutdown records causes; a cause active at other times
        // leaves its flag alone.
        if (GLOBAL_SHUTDOWN) begin
            set_vec = cause_s;
        end
        // accumulate until read
        // The set is OR-ed in after the clear, so a shutdown landing in the
        // same cycle as the read is kept for the next read.
        log_nxt = (log_read ? `SCS_LOG_CLEAR : log_r) | set_vec;
        rd_valid_nxt = RD_STB;
        if (log_read) begin
            // The read returns the value before this cycle's clear.
            rd_data_nxt = log_r;
        end else if (RD_STB) begin
            // Other addresses belong to other blocks; answer with zero.
            rd_data_nxt = `SCS_UNMAPPED_DATA;
        end else begin
            rd_data_nxt = rd_data_r;
        end
        // The clock enable freezes every register.
        if (!CE) begin
            log_nxt = log_r;
            rd_valid_nxt = rd_valid_r;
            rd_data_nxt = rd_data_r;
        end
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            log_r <= `SCS_LOG_RESET;
            rd_data_r <= 8'h00;
            rd_valid_r <= 1'b0;
        end else begin
            log_r <= log_nxt;
            rd_data_r <= rd_data_nxt;
            rd_valid_r <= rd_valid_nxt;
        end
    end

    assign RD_DATA = rd_data_r;
    assign RD_VALID = rd_valid_r;

    // -------------------------------------------------------------------------
    // Momentary power loss recovery
    // -------------------------------------------------------------------------
    scs_pkg::scs_rec_state_type state_r;  // Recovery watcher state.
    scs_pkg::scs_rec_state_type state_nxt;
    logic [31:0] cnt_r;                   // Cycles left in the dropout window.
    logic [31:0] cnt_nxt;
    logic restart_r;                      // Registered restart request pulse.
    logic restart_nxt;

    // After an undervoltage shutdown with recovery enabled, watch the battery;
    // if it returns before the window closes, ask the sequencer to restart.
    // A longer dropout is treated as a genuine dead battery and stays off.
    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        restart_nxt = 1'b0;
        case (state_r)
            scs_pkg::SCS_REC_IDLE: begin
                if (GLOBAL_SHUTDOWN && cause_s.battery_undervoltage_cause && MOMENTARY_POWER_LOSS_RECOVERY) begin
                    state_nxt = scs_pkg::SCS_REC_WAIT;
                    cnt_nxt = 32'(RECOVER_CYC - 1);
                end
            end
            scs_pkg::SCS_REC_WAIT: begin
                if (!cause_s.battery_undervoltage_cause) begin
                    restart_nxt = 1'b1;
                    state_nxt = scs_pkg::SCS_REC_IDLE;
                end else if (cnt_r == 32'h0000_0000) begin
                    // Window expired; remain shut down.
                    state_nxt = scs_pkg::SCS_REC_IDLE;
                end else begin
                    cnt_nxt = cnt_r - 32'h0000_0001;
                end
            end
            default: begin
                state_nxt = scs_pkg::SCS_REC_IDLE;
            end
        endcase
        if (!CE) begin
            state_nxt = state_r;
            cnt_nxt = cnt_r;
            restart_nxt = restart_r;
        end
    end

    // Registers for the recovery watcher.
    always_ff @(posedge CLK) begin
        if (RESET) begin
            state_r <= scs_pkg::SCS_REC_IDLE;
            cnt_r <= 32'h0000_0000;
            restart_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            restart_r <= restart_nxt;
        end
    end

    assign RESTART_REQ = restart_r;

    // -------------------------------------------------------------------------
    // Assertions
    // -------------------------------------------------------------------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RESET);

    // A shutdown sample, used by the flag checks.
    sequence shut_s;
        CE && GLOBAL_SHUTDOWN;
    endsequence

    // An undervoltage shutdown with recovery armed.
    sequence uv_arm_s;
        CE && GLOBAL_SHUTDOWN && cause_s.battery_undervoltage_cause && MOMENTARY_POWER_LOSS_RECOVERY
            && state_r == scs_pkg::SCS_REC_IDLE;
    endsequence

    // Battery seen back while the dropout window is open, with the clock running.
    // The synchroniser lag means this can fall several cycles after the arming.
    sequence uv_back_s;
        CE && !cause_s.battery_undervoltage_cause && state_r == scs_pkg::SCS_REC_WAIT;
    endsequence

    reset_input_cause_flag_a: assert property (shut_s and cause_s.reset_input_cause |=> log_r[7])
        else $error("reset input cause not logged");
    uv_flag_a: assert property (shut_s and cause_s.battery_undervoltage_cause |=> log_r[6])
        else $error("undervoltage cause not logged");
    recover_arm_a: assert property (uv_arm_s |=> state_r == scs_pkg::SCS_REC_WAIT)
        else $error("recovery window not armed");
    recover_restart_a: assert property (uv_back_s |=> RESTART_REQ)
        else $error("no restart after brief dropout");
    ov_flag_a: assert property (shut_s and cause_s.battery_overvoltage_cause |=> log_r[5])
        else $error("overvoltage cause not logged");
    low_flag_a: assert property (shut_s and cause_sync[4] && LOW_BATTERY_SHUTDOWN_ENABLE |=> log_r[4])
        else $error("battery low cause not logged");
    thermal_flag_a: assert property (shut_s and cause_s.thermal_overload_cause |=> log_r[3])
        else $error("thermal cause not logged");
    hard_flag_a: assert property (shut_s and cause_s.manual_hard_reset_cause |=> log_r[2])
        else $error("hard reset cause not logged");
    wdog_flag_a: assert property (shut_s and cause_s.watchdog_cause |=> log_r[1])
        else $error("watchdog cause not logged");
    pin_flag_a: assert property (shut_s and cause_s.shutdown_pin_cause |=> log_r[0])
        else $error("shutdown pin cause not logged");
    read_clear_a: assert property (CE && log_read && !GLOBAL_SHUTDOWN |=> log_r == 8'h00 && RD_DATA == $past(log_r))
        else $error("read did not return and clear log");
    log_hold_a: assert property (!(CE && (GLOBAL_SHUTDOWN || log_read)) |=> log_r == $past(log_r))
        else $error("log changed without shutdown or read");
    no_cause_a: assert property (CE && log_read && !(GLOBAL_SHUTDOWN && cause_s.watchdog_cause) |=> !log_r[1])
        else $error("uncaused flag set");

endmodule : scs_shutdown_cause_recorder

// >>> scs_params.svh
//------------------------------------------------------------------------------
// Purpose: Constants for the shutdown cause recorder: address, fields, timing.
// Assumes: A 25 MHz block clock.
// Notes:   Definitions only; included by its bare name.
//------------------------------------------------------------------------------
`ifndef SCS_PARAMS_SVH
`define SCS_PARAMS_SVH

// -----------------------------------------------------------------------------
// Register map
// -----------------------------------------------------------------------------
// Register address of the shutdown cause log.
`define SCS_LOG_ADDR 8'h0c
// Value after a backup supply undervoltage reset.
`define SCS_LOG_RESET 8'h40
// Value to which a read clears the log.
`define SCS_LOG_CLEAR 8'h00
// Value returned for any other address.
`define SCS_UNMAPPED_DATA 8'h00

// -----------------------------------------------------------------------------
// Field positions
// -----------------------------------------------------------------------------
`define SCS_BIT_RESET_INPUT 7
`define SCS_BIT_BATT_UV 6
`define SCS_BIT_BATT_OV 5
`define SCS_BIT_BATT_LOW 4
`define SCS_BIT_THERMAL 3
`define SCS_BIT_HARD_RESET 2
`define SCS_BIT_WATCHDOG 1
`define SCS_BIT_SHUTDOWN_PIN 0

// -----------------------------------------------------------------------------
// Timing
// -----------------------------------------------------------------------------
// Clock rate in MHz.
`define SCS_CLK_MHZ 25
// Longest battery dropout, in microseconds, that still allows a restart.
`define SCS_RECOVER_US 2000
// The same window in clock cycles (a longest time, so rounded down).
`define SCS_RECOVER_CYC (`SCS_RECOVER_US * `SCS_CLK_MHZ)

`endif

// >>> scs_pkg.sv
//------------------------------------------------------------------------------
// Purpose: Types shared by the shutdown cause recorder files.
// Assumes: Nothing beyond the params header.
// Notes:   Used only through scs_pkg:: names.
//------------------------------------------------------------------------------
package scs_pkg;

    // -------------------------------------------------------------------------
    // Cause vector, laid out exactly as the log register bits 7 down to 0.
    // -------------------------------------------------------------------------
    typedef struct packed {
        logic reset_input_cause;
        logic battery_undervoltage_cause;
        logic battery_overvoltage_cause;
        logic battery_low_cause;
        logic thermal_overload_cause;
        logic manual_hard_reset_cause;
        logic watchdog_cause;
        logic shutdown_pin_cause;
    } scs_cause_type;

    // -------------------------------------------------------------------------
    // States of the momentary power loss recovery watcher.
    // -------------------------------------------------------------------------
    typedef enum logic [0:0] {
        SCS_REC_IDLE,
        SCS_REC_WAIT
    } scs_rec_state_type;

endpackage : scs_pkg

// >>> scs_sync.sv
//------------------------------------------------------------------------------
// Purpose: Two flip-flop synchroniser bank for asynchronous cause inputs.
// Assumes: Each input is a level held for several clock cycles.
// Notes:   The first stage feeds only the second stage.
//------------------------------------------------------------------------------
module scs_sync #(
    parameter int WIDTH = 8
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);

    // -------------------------------------------------------------------------
    // One pair of flops per bit.
    // -------------------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            logic meta_r;  // First stage, may go metastable.
            logic sync_r;  // Second stage, safe to read.
            logic meta_nxt;
            logic sync_nxt;

            // Next values: hold while the clock enable is low.
            always_comb begin
                meta_nxt = ce ? d[i] : meta_r;
                sync_nxt = ce ? meta_r : sync_r;
            end

            // Registers clear to zero so no cause is seen out of reset.
            always_ff @(posedge clk) begin
                if (reset) begin
                    meta_r <= 1'b0;
                    sync_r <= 1'b0;
                end else begin
                    meta_r <= meta_nxt;
                    sync_r <= sync_nxt;
                end
            end

            assign q[i] = sync_r;
        end
    endgenerate

endmodule : scs_sync

// >>> scs_host_model.sv
//------------------------------------------------------------------------------
// Purpose: Host side model that reads the shutdown cause log over the read port.
// Assumes: Reads are taken at the rising edge where the strobe is high.
// Notes:   The address lines are scrambled when idle so stale values cannot pass.
//------------------------------------------------------------------------------
module scs_host_model (
    input wire logic clk,
    output logic rd_stb,
    output logic [7:0] rd_addr,
    input wire logic [7:0] rd_data,
    input wire logic rd_valid
);
    timeunit 1ns;
    timeprecision 100ps;

    // Idle bus: no strobe, and an address that no test relies on.
    initial begin
        rd_stb = 1'b0;
        rd_addr = 8'h00;
    end

    // -------------------------------------------------------------------------
    // Read cycle
    // -------------------------------------------------------------------------
    // One strobe cycle; the answer is taken just after the following edge.
    // The address is inverted on release, so a design that samples late fails.
    task automatic read(input logic [7:0] addr, input int gap, output logic [7:0] data, output logic valid);
        repeat (gap) @(posedge clk);
        @(posedge clk);
        #1;
        rd_stb = 1'b1;
        rd_addr = addr;
        @(posedge clk);
        #1;
        rd_stb = 1'b0;
        rd_addr = ~addr;
        valid = rd_valid;
        data = rd_data;
    endtask : read

endmodule : scs_host_model

// >>> scs_shutdown_cause_recorder_bench.sv
//------------------------------------------------------------------------------
// Purpose: Self-checking bench for the shutdown cause recorder.
// Assumes: A short recovery window so the dropout tests stay brief.
// Notes:   Cause inputs are held three edges before each shutdown pulse.
//------------------------------------------------------------------------------
`include "scs_params.svh"

module scs_shutdown_cause_recorder_bench;
    timeunit 1ns;
    timeprecision 100ps;

    // Shortened recovery window; the restart-count windows below are derived from it.
    localparam int REC_CYC = 20;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic ce = 1'b1;
    logic gs = 1'b0;
    logic lb_en = 1'b0;
    logic rec_en = 1'b0;
    scs_pkg::scs_cause_type cause = '0;
    logic rd_stb;
    logic [7:0] rd_addr;
    logic [7:0] rd_data;
    logic rd_valid;
    logic restart;
    int failures = 0;
    int tests_run = 0;

    // 25 MHz block clock.
    always #20 clk = ~clk;

    scs_shutdown_cause_recorder #(.RECOVER_CYC(REC_CYC)) dut_u (
        .CLK(clk), .RESET(reset), .CE(ce), .GLOBAL_SHUTDOWN(gs),
        .EXTERNAL_RESET_INPUT(cause.reset_input_cause), .BATT_UNDERVOLTAGE(cause.battery_undervoltage_cause),
        .BATT_OVERVOLTAGE(cause.battery_overvoltage_cause), .BATT_LOW(cause.battery_low_cause),
        .LOW_BATTERY_SHUTDOWN_ENABLE(lb_en), .THERMAL_OVERLOAD(cause.thermal_overload_cause),
        .HARD_RESET_EVENT(cause.manual_hard_reset_cause), .WATCHDOG_EXPIRED(cause.watchdog_cause),
        .SHUTDOWN_PIN(cause.shutdown_pin_cause), .MOMENTARY_POWER_LOSS_RECOVERY(rec_en),
        .RD_STB(rd_stb), .RD_ADDR(rd_addr), .RD_DATA(rd_data), .RD_VALID(rd_valid), .RESTART_REQ(restart)
    );

    scs_host_model host_u (.clk(clk), .rd_stb(rd_stb), .rd_addr(rd_addr), .rd_data(rd_data), .rd_valid(rd_valid));

    // -------------------------------------------------------------------------
    // Shared helpers
    // -------------------------------------------------------------------------
    // Compare task for all byte and flag results; a flag is zero-extended.
    task automatic check8(input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: expected %h, got %h", $time, exp, got);
        end
    endtask : check8

    // Inputs change one nanosecond after the edge, never on it.
    task automatic tick;
        @(posedge clk);
        #1;
    endtask : tick

    // Read the log (or another address) and judge the valid pulse and data.
    task automatic read_chk(input logic [7:0] addr, input logic [7:0] exp);
        logic [7:0] d;
        logic v;
        host_u.read(addr, 0, d, v);
        check8(8'h01, {7'h00, v});
        check8(exp, d);
    endtask : read_chk

    // Raise the causes, let the synchroniser settle, then pulse a shutdown.
    task automatic shutdown(input logic [7:0] c, input logic keep);
        cause = scs_pkg::scs_cause_type'(c);
        repeat (3) tick();
        gs = 1'b1;
        tick();
        gs = 1'b0;
        if (!keep) begin
            cause = '0;
        end
    endtask : shutdown

    // Count restart pulses over a fixed number of cycles.
    task automatic count_restart(input int n, output int cnt);
        cnt = 0;
        repeat (n) begin
            tick();
            if (restart !== 1'b0) begin
                cnt++;
            end
        end
    endtask : count_restart

    // -------------------------------------------------------------------------
    // Scenarios
    // -------------------------------------------------------------------------
    // Power-up value, then the clearing effect of a read.
    task automatic t_reset_value;
        read_chk(`SCS_LOG_ADDR, `SCS_LOG_RESET);
        read_chk(`SCS_LOG_ADDR, `SCS_LOG_CLEAR);
    endtask : t_reset_value

    // Every cause alone must set only its own bit.
    task automatic t_each_cause;
        lb_en = 1'b1;
        for (int i = 0; i < 8; i++) begin
            shutdown(8'h01 << i, 1'b0);
            read_chk(`SCS_LOG_ADDR, 8'h01 << i);
        end
    endtask : t_each_cause

    // A low battery without the shutdown option must leave the log empty.
    task automatic t_low_gated;
        lb_en = 1'b0;
        shutdown(8'h10, 1'b0);
        read_chk(`SCS_LOG_ADDR, 8'h00);
    endtask : t_low_gated

    // Flags pile up; an unmapped read answers with zero and does not clear them.
    task automatic t_accumulate;
        shutdown(8'h81, 1'b0);
        shutdown(8'h02, 1'b0);
        read_chk(8'h0d, `SCS_UNMAPPED_DATA);
        read_chk(`SCS_LOG_ADDR, 8'h83);
        read_chk(`SCS_LOG_ADDR, 8'h00);
    endtask : t_accumulate

    // Read and shutdown on the same edge: old value out, new flag kept.
    task automatic t_collide;
        logic [7:0] d;
        logic v;
        shutdown(8'h08, 1'b0);
        cause = scs_pkg::scs_cause_type'(8'h04);
        repeat (3) tick();
        fork
            host_u.read(`SCS_LOG_ADDR, 0, d, v);
            begin
                tick();
                gs = 1'b1;
                tick();
                gs = 1'b0;
            end
        join
        cause = '0;
        check8(8'h08, d);
        read_chk(`SCS_LOG_ADDR, 8'h04);
    endtask : t_collide

    // Brief dropout restarts once; a dropout outlasting the window does not.
    task automatic t_recovery;
        int cnt;
        rec_en = 1'b1;
        shutdown(8'h40, 1'b0);
        count_restart(REC_CYC + 5, cnt);
        check8(8'h01, cnt[7:0]);
        read_chk(`SCS_LOG_ADDR, 8'h40);
        shutdown(8'h40, 1'b1);
        count_restart(REC_CYC + 10, cnt);
        check8(8'h00, cnt[7:0]);
        cause = '0;
        count_restart(5, cnt);
        check8(8'h00, cnt[7:0]);
        rec_en = 1'b0;
        read_chk(`SCS_LOG_ADDR, 8'h40);
    endtask : t_recovery

    // With the clock enable low a strobe is ignored and clears nothing.
    task automatic t_ce_low;
        logic [7:0] d;
        logic v;
        shutdown(8'h20, 1'b0);
        ce = 1'b0;
        host_u.read(`SCS_LOG_ADDR, 2, d, v);
        check8(8'h00, {7'h00, v});
        ce = 1'b1;
        read_chk(`SCS_LOG_ADDR, 8'h20);
    endtask : t_ce_low

    // A backup supply reset in mid-run restores the power-up value.
    task automatic t_midreset;
        shutdown(8'h02, 1'b0);
        reset = 1'b1;
        tick();
        reset = 1'b0;
        read_chk(`SCS_LOG_ADDR, `SCS_LOG_RESET);
    endtask : t_midreset

    // -------------------------------------------------------------------------
    // Verdict and run control
    // -------------------------------------------------------------------------
    task automatic final_report;
        if (failures == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : final_report

    // Main sequence: two reset cycles, then every scenario in turn.
    initial begin
        repeat (2) @(posedge clk);
        #1;
        reset = 1'b0;
        t_reset_value();
        t_each_cause();
        t_low_gated();
        t_accumulate();
        t_collide();
        t_recovery();
        t_ce_low();
        t_midreset();
        final_report();
    end

    // The tests need well under a thousand cycles; this cuts off a hang.
    initial begin
        #200000;
        failures++;
        final_report();
    end

endmodule : scs_shutdown_cause_recorder_bench
